/* logic/wss_pkg.sv */
/*
  shared constants and types of the waveform steering and source select block.
  assumes a 32-bit classic wishbone register bus and a single 250 MHz clock.
*/
`default_nettype none

package wss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_CLK_SEL = 8'h00;
  localparam logic [7:0] OFF_IN_SEL = 8'h04;
  localparam logic [7:0] OFF_STEER = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // field positions and widths
  localparam int CS_BIT = 0;
  localparam int SRC_W = 4;
  localparam int PIN_N = 4;
  localparam int SYNC_BIT = 4;
  localparam int STAT_PEND_BIT = 4;
  localparam int STAT_DATA_BIT = 5;

  // reset values
  localparam logic RST_CS = 1'h0;
  localparam logic [3:0] RST_SRC = 4'h0;
  localparam logic [3:0] RST_STEER = 4'h0;
  localparam logic RST_SYNC = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // input source codes; 4'hb..4'hf are reserved and connect nothing
  localparam logic [3:0] SRC_PIN = 4'h0;
  localparam logic [3:0] SRC_CCP1 = 4'h1;
  localparam logic [3:0] SRC_CCP2 = 4'h2;
  localparam logic [3:0] SRC_PWM3 = 4'h3;
  localparam logic [3:0] SRC_PWM4 = 4'h4;
  localparam logic [3:0] SRC_CMP1 = 4'h5;
  localparam logic [3:0] SRC_CMP2 = 4'h6;
  localparam logic [3:0] SRC_LC1 = 4'h7;
  localparam logic [3:0] SRC_LC2 = 4'h8;
  localparam logic [3:0] SRC_LC3 = 4'h9;
  localparam logic [3:0] SRC_LC4 = 4'ha;

  ////////////////////////////////////////////////////////////////////////////
  // timing: module clock rates in MHz
  localparam int CLK_MHZ = 250;
  localparam int FAST_OSC_MHZ = 16;
  localparam int FAST_DIV = CLK_MHZ / FAST_OSC_MHZ;
  localparam int DIV_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // on-chip signal sources feeding the selector
  typedef struct packed {
    logic [3:0] logic_cell;
    logic [1:0] comparator;
    logic [1:0] pwm;
    logic [1:0] capture;
    logic pin;
  } wss_src_t;

  typedef enum logic [0:0] {
    STEER_IDLE = 1'b0,
    STEER_PENDING = 1'b1
  } wss_steer_state_t;

endpackage

`default_nettype wire

/* logic/wss_top.sv */
/*
  waveform steering and source select: source mux, module clock enable,
  steering of the selected data to four output pins, wishbone register slave.
  assumes all inputs are synchronous to clk_i and the bus master is classic
  wishbone with one outstanding request.
*/
// Notes on behaviour
// RULE1 - selected data can drive any combination of the four output pins, including none.
// RULE2 - in synchronous mode a new steering value applies on the next rising data edge.
// RULE3 - in non-synchronous mode a new steering value applies on the next module cycle.
// RULE4 - clock select one picks the 16 MHz oscillator rate, zero the system clock; default FAST_DIV is 15, so the code gives 250/15, about 16.7 MHz.
// RULE5 - clock select register holds bit zero, resets to zero, upper bits read zero.
// RULE6 - input select holds a four-bit field resetting to zero, upper bits read zero.
// RULE7 - source codes eleven to fifteen connect nothing; data input stays inactive.
// RULE8 - codes ten to seven pick logic cells four to one; code six comparator two.
// RULE9 - codes five to one pick comparator one, pwm four, pwm three, capture two, one.
`timescale 1ns/100ps
`default_nettype none

module wss_top #(
  parameter int FAST_DIV = wss_pkg::FAST_DIV
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // signal sources
  input wire wss_pkg::wss_src_t src_i,
  // steered output pins
  output logic [3:0] pins_o
);

  ////////////////////////////////////////////////////////////////////////////
  // source decode
  function automatic logic pick_source(input logic [3:0] code, input wss_pkg::wss_src_t s);
    case (code)
      wss_pkg::SRC_PIN: pick_source = s.pin;
      wss_pkg::SRC_CCP1: pick_source = s.capture[0];
      wss_pkg::SRC_CCP2: pick_source = s.capture[1];
      wss_pkg::SRC_PWM3: pick_source = s.pwm[0];
      wss_pkg::SRC_PWM4: pick_source = s.pwm[1];
      wss_pkg::SRC_CMP1: pick_source = s.comparator[0];
      wss_pkg::SRC_CMP2: pick_source = s.comparator[1];
      wss_pkg::SRC_LC1: pick_source = s.logic_cell[0];
      wss_pkg::SRC_LC2: pick_source = s.logic_cell[1];
      wss_pkg::SRC_LC3: pick_source = s.logic_cell[2];
      wss_pkg::SRC_LC4: pick_source = s.logic_cell[3];
      default: pick_source = 1'b0;
    endcase
  endfunction

  logic clk_sel_reg;
  logic [3:0] src_sel_reg;
  logic [3:0] steer_req_reg;
  logic sync_mode_reg;
  logic [3:0] steer_act_reg;
  logic data_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [3:0] pins_reg;
  logic [wss_pkg::DIV_W-1:0] div_reg;
  wss_pkg::wss_steer_state_t state_reg;
  wss_pkg::wss_steer_state_t state_next;
  logic [3:0] steer_act_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; answers one cycle after the request, unmapped reads give zero
  wire req = cyc_i & stb_i & ~ack_reg;
  wire wr_ok = req & we_i & sel_i[0];
  wire wr_clk = wr_ok & (adr_i == wss_pkg::OFF_CLK_SEL);
  wire wr_src = wr_ok & (adr_i == wss_pkg::OFF_IN_SEL);
  wire wr_steer = wr_ok & (adr_i == wss_pkg::OFF_STEER);
  wire pending = (state_reg == wss_pkg::STEER_PENDING);
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0;
    case (adr_i)
      wss_pkg::OFF_CLK_SEL: rd_data[wss_pkg::CS_BIT] = clk_sel_reg; // [RULE5]
      wss_pkg::OFF_IN_SEL: rd_data[wss_pkg::SRC_W-1:0] = src_sel_reg; // [RULE6]
      wss_pkg::OFF_STEER: rd_data[wss_pkg::SYNC_BIT:0] = {sync_mode_reg, steer_req_reg};
      wss_pkg::OFF_STATUS: rd_data[wss_pkg::STAT_DATA_BIT:0] = {data_reg, pending, steer_act_reg};
      default: rd_data = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // module clock: every cycle on the system clock, or a divided enable pulse
  localparam int DIV_W = wss_pkg::DIV_W;
  wire div_end = (div_reg == DIV_W'(FAST_DIV - 1));
  wire tick = clk_sel_reg ? div_end : 1'b1; // [RULE4]
  wire sel_data = pick_source(src_sel_reg, src_i); // [RULE7] [RULE8] [RULE9]
  wire rise = tick & sel_data & ~data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // steering: a written value waits in the pending state until it may apply
  always_comb begin
    state_next = state_reg;
    steer_act_next = steer_act_reg;
    case (state_reg)
      wss_pkg::STEER_IDLE: begin
        if (wr_steer) begin
          state_next = wss_pkg::STEER_PENDING;
        end
      end
      wss_pkg::STEER_PENDING: begin
        if (sync_mode_reg ? rise : tick) begin // [RULE2] [RULE3]
          steer_act_next = steer_req_reg;
          state_next = wr_steer ? wss_pkg::STEER_PENDING : wss_pkg::STEER_IDLE;
        end
      end
      default: state_next = wss_pkg::STEER_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sel_reg <= wss_pkg::RST_CS;
      src_sel_reg <= wss_pkg::RST_SRC;
      steer_req_reg <= wss_pkg::RST_STEER;
      sync_mode_reg <= wss_pkg::RST_SYNC;
      steer_act_reg <= wss_pkg::RST_STEER;
      state_reg <= wss_pkg::STEER_IDLE;
      data_reg <= 1'b0;
      div_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      pins_reg <= 4'h0;
    end else begin
      ack_reg <= req;
      if (req) begin
        dat_reg <= rd_data;
      end
      if (wr_clk) begin
        clk_sel_reg <= dat_i[wss_pkg::CS_BIT]; // [RULE5]
      end
      if (wr_src) begin
        src_sel_reg <= dat_i[wss_pkg::SRC_W-1:0]; // [RULE6]
      end
      if (wr_steer) begin
        steer_req_reg <= dat_i[wss_pkg::PIN_N-1:0];
        sync_mode_reg <= dat_i[wss_pkg::SYNC_BIT];
      end
      state_reg <= state_next;
      steer_act_reg <= steer_act_next;
      div_reg <= div_end ? '0 : div_reg + 1'b1;
      if (tick) begin
        data_reg <= sel_data;
      end
      // one register stage so pins come straight from flops
      pins_reg <= steer_act_reg & {wss_pkg::PIN_N{data_reg}}; // [RULE1]
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign pins_o = pins_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // checker helpers: system clocks since the last module tick, and whether a tick
  // has passed since the oscillator rate was chosen; the divider runs free, so the
  // first tick after the switch may come early and is not held to the period
  localparam int GAP_W = wss_pkg::DIV_W + 1;
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(FAST_DIV - 1);
  logic [GAP_W-1:0] gap_reg;
  logic fast_armed_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || tick || !clk_sel_reg) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= gap_reg + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !clk_sel_reg) begin
      fast_armed_reg <= 1'b0;
    end else if (tick) begin
      fast_armed_reg <= 1'b1;
    end
  end

  chk_pins_steered: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    ##1 pins_o == ($past(steer_act_reg) & {wss_pkg::PIN_N{$past(data_reg)}}))
    else $error("output pins do not follow steering and data");
  chk_sync_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    pending && sync_mode_reg && !rise |=> $stable(steer_act_reg))
    else $error("synchronous steering changed without a rising edge");
  chk_sync_apply: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    pending && sync_mode_reg && rise |=> steer_act_reg == $past(steer_req_reg) && data_reg)
    else $error("synchronous steering not applied at rising edge");
  chk_async_apply: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    wr_steer && !dat_i[wss_pkg::SYNC_BIT] && !clk_sel_reg && !wr_clk
    |=> ##1 steer_act_reg == $past(dat_i[wss_pkg::PIN_N-1:0], 2))
    else $error("non-synchronous steering not applied next cycle");
  chk_fast_rate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    clk_sel_reg && fast_armed_reg |-> tick == (gap_reg == GAP_LAST))
    else $error("oscillator enable not once every fast period");
  chk_sys_rate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
    !clk_sel_reg |-> tick)
    else $error("system clock selection lost a cycle");
  chk_clk_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
    req && !we_i && adr_i == wss_pkg::OFF_CLK_SEL |=> ack_o && dat_o == {31'h0, clk_sel_reg})
    else $error("clock select read wrong");
  chk_src_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    req && !we_i && adr_i == wss_pkg::OFF_IN_SEL |=> ack_o && dat_o == {28'h0, src_sel_reg})
    else $error("input select read wrong");
  chk_reserved_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    src_sel_reg > wss_pkg::SRC_LC4 && tick |=> !data_reg)
    else $error("reserved source code passed data");
  chk_cell_four: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    src_sel_reg == wss_pkg::SRC_LC4 && tick |=> data_reg == $past(src_i.logic_cell[3]))
    else $error("logic cell four not selected");
  chk_cmp_one: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    src_sel_reg == wss_pkg::SRC_CMP1 && tick |=> data_reg == $past(src_i.comparator[0]))
    else $error("comparator one not selected");

  cov_sync_apply: cover property (@(posedge clk_i) disable iff (rst_i)
    pending && sync_mode_reg && rise);
  cov_async_apply: cover property (@(posedge clk_i) disable iff (rst_i)
    pending && !sync_mode_reg && tick);
  cov_fast_clock: cover property (@(posedge clk_i) disable iff (rst_i)
    clk_sel_reg && rise);
  cov_all_pins: cover property (@(posedge clk_i) disable iff (rst_i) pins_o == 4'hf);

endmodule // wss_top

`default_nettype wire

/* testbench/wss_src_model.sv */
/*
  partner model: the on-chip signal sources that feed the source selector.
  assumes the bench commands every source level; the sources change after clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module wss_src_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commanded levels, one bit per source in struct order
  input wire logic [10:0] level_i,
  // sources towards the block
  output wss_pkg::wss_src_t src_o
);
  // real sources are registered outputs of other peripherals, so one cycle of lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_o <= '0;
    end else begin
      src_o <= level_i;
    end
  end
endmodule // wss_src_model

`default_nettype wire

/* testbench/wss_top_test.sv */
/*
  self-checking bench: wishbone register access, source map, steering, clock select.
  assumes the design acks every request and uses a shortened fast divider.
*/
`timescale 1ns/100ps
`default_nettype none

module wss_top_test;
  localparam int FD = 4;
  logic clk_i, rst_i, we, cyc, stb, ack;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [3:0] sel, pins;
  logic [10:0] level;
  wss_pkg::wss_src_t src;
  int error_cnt = 0;
  int checks_done = 0;
  int tot, cnt, bad;

  wss_src_model wss_src_model_inst (.clk_i(clk_i), .rst_i(rst_i), .level_i(level), .src_o(src));
  wss_top #(.FAST_DIV(FD)) wss_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .src_i(src), .pins_o(pins));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered right after a rising edge; ack is read as that edge samples it
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] r);
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    // only the watchdog ends a wait that never sees ack
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    {we, cyc, stb} = 3'h0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'hf;
    level = 11'h000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(wss_pkg::OFF_CLK_SEL, 1'b0, 32'h0, q); chk(q, 32'h0);
    wb(wss_pkg::OFF_IN_SEL, 1'b0, 32'h0, q); chk(q, 32'h0);
    wb(wss_pkg::OFF_CLK_SEL, 1'b1, 32'hff, q);
    wb(wss_pkg::OFF_CLK_SEL, 1'b0, 32'h0, q); chk(q, 32'h1);
    wb(wss_pkg::OFF_IN_SEL, 1'b1, 32'hff, q);
    sel <= 4'h0;
    wb(wss_pkg::OFF_IN_SEL, 1'b1, 32'h0, q);
    sel <= 4'hf;
    wb(wss_pkg::OFF_IN_SEL, 1'b0, 32'h0, q); chk(q, 32'hf);
    wb(8'h10, 1'b1, 32'hff, q);
    wb(8'h10, 1'b0, 32'h0, q); chk(q, 32'h0);
    wb(wss_pkg::OFF_CLK_SEL, 1'b1, 32'h0, q);
    // every source code: only the mapped source may reach the pins
    wb(wss_pkg::OFF_STEER, 1'b1, 32'hf, q);
    for (int k = 0; k < 16; k++) begin
      wb(wss_pkg::OFF_IN_SEL, 1'b1, 32'(k), q);
      level <= (k < 11) ? 11'h1 << k : 11'h7ff;
      repeat (4) @(posedge clk_i);
      chk(pins, (k < 11) ? 32'hf : 32'h0);
      level <= ~(11'h1 << k);
      repeat (4) @(posedge clk_i);
      chk(pins, 32'h0);
    end
    // every pin combination, applied without an input edge
    wb(wss_pkg::OFF_IN_SEL, 1'b1, 32'h0, q);
    level <= 11'h001;
    for (int s = 0; s < 16; s++) begin
      wb(wss_pkg::OFF_STEER, 1'b1, 32'(s), q);
      repeat (3) @(posedge clk_i);
      chk(pins, 32'(s));
    end
    // synchronous mode waits for the rising data edge
    wb(wss_pkg::OFF_STEER, 1'b1, 32'ha, q);
    level <= 11'h000;
    repeat (4) @(posedge clk_i);
    wb(wss_pkg::OFF_STEER, 1'b1, 32'h15, q);
    repeat (6) @(posedge clk_i);
    wb(wss_pkg::OFF_STEER, 1'b0, 32'h0, q); chk(q, 32'h15);
    wb(wss_pkg::OFF_STATUS, 1'b0, 32'h0, q); chk(q, 32'h1a);
    level <= 11'h001;
    repeat (4) @(posedge clk_i);
    chk(pins, 32'h5);
    // slow clock: a one-cycle pulse is caught by one tick in four phases
    wb(wss_pkg::OFF_STEER, 1'b1, 32'hf, q);
    level <= 11'h000;
    wb(wss_pkg::OFF_CLK_SEL, 1'b1, 32'h1, q);
    repeat (2 * FD) @(posedge clk_i);
    tot = 0;
    bad = 0;
    for (int i = 0; i < 4; i++) begin
      level <= 11'h001;
      @(posedge clk_i);
      level <= 11'h000;
      cnt = 0;
      repeat (12) begin
        @(posedge clk_i);
        if (pins !== 4'h0) cnt++;
      end
      tot += cnt;
      if (cnt != 0 && cnt != FD) bad++;
    end
    chk(32'(tot), 32'(FD));
    chk(32'(bad), 32'h0);
    end_sim();
  end
endmodule // wss_top_test

`default_nettype wire
